// File: hw/crf_defs.svh
// Constants of the capture record formatter
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ----------------------------------------------------------------------------
// Record layout
// ----------------------------------------------------------------------------
`define CRF_HDR_BYTES       16'h0010
`define CRF_ETH_EXTRA       16'h0002
`define CRF_OFFSET_BYTE     8'h00
`define CRF_PAD_BYTE        8'h00
`define CRF_TYPE_PLAIN      8'h02
`define CRF_TYPE_CLASSIFIED 8'h10
`define CRF_FLAGS_IFACE_LSB 0
`define CRF_FLAGS_CAPOFF    6'h00

// ----------------------------------------------------------------------------
// Loss counter, timestamp and FIFO depth
// ----------------------------------------------------------------------------
`define CRF_LOSS_RESET      16'h0000
`define CRF_LOSS_MAX        16'hffff
`define CRF_TS_FRAC_FULL    32
`define CRF_FIFO_DEPTH      8

`endif

// File: hw/crf_fifo.sv
// Word FIFO between the record formatter and the host bus
`timescale 1ns/1ps
`default_nettype none

module crf_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,       // Capture clock
  input  wire logic             rst,       // Async reset, high
  input  wire logic             in_valid,  // Word offered
  input  wire logic [WIDTH-1:0] in_data,   // Word in
  output logic                  in_ready,  // Room for a word
  output logic                  out_valid, // Output word held
  output logic      [WIDTH-1:0] out_data,  // Output word, registered
  input  wire logic             out_ready  // Sink takes the word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 count;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        take_out;
  logic        put_in;
  logic        pop_mem;

  always_comb begin
    next_s   = s;
    in_ready = (s.count != (AW+1)'(DEPTH));
    put_in   = in_valid && in_ready;
    take_out = s.ov && out_ready;
    pop_mem  = (s.count != '0) && (!s.ov || take_out);
    if (take_out) begin
      next_s.ov = 1'b0;
    end
    // Output stage refills from memory so read data leave a register
    if (pop_mem) begin
      next_s.od = s.mem[s.rp];
      next_s.ov = 1'b1;
      next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
    end
    if (put_in) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
    end
    next_s.count = s.count + (AW+1)'(put_in) - (AW+1)'(pop_mem);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_valid = s.ov;
  assign out_data  = s.od;

  full_stall_a: assert property (@(posedge clk) disable iff (rst)
    (s.count == (AW+1)'(DEPTH)) |-> !in_ready) else $error("fifo takes word when full");
endmodule

`default_nettype wire

// File: hw/crf_formatter.sv
// Capture record formatter: frames in, host-bound capture_record words out
//
// Summary of operation
// - Timestamp little-endian, other header fields big-endian.
// - Payload copied bytewise in arrival order.
// - Sixteen-byte generic header precedes record bytes.
// - Type 2 plain, 16 classified.
// - Flags carry interface and capture offset.
// - Record length counts whole record.
// - Saturating 16-bit count of dropped records.
// - Wire length reports line length.
// - Capture offset unused; consumer ignores it.
// - Offset and pad bytes align layer three.
// - Classified record carries colour instead of loss.
// - Hardware stamps arrival time at frame start.
// - Single 64-bit fixed-point seconds since epoch.
// - Upper word seconds, lower word fraction.
// - Unresolved fraction bits forced to zero.
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"

module crf_formatter #(
  parameter int TS_FRAC_BITS = `CRF_TS_FRAC_FULL,
  parameter int FIFO_DEPTH   = `CRF_FIFO_DEPTH
) (
  input  wire logic        CLOCK,          // Capture clock, 100 MHz
  input  wire logic        RST,            // Async reset, high
  input  wire logic [63:0] TS_NOW,         // Disciplined time, fixed point
  input  wire logic        FRM_START,      // Pulse: new frame descriptor
  input  wire logic [15:0] FRM_LEN,        // Captured bytes, at least 1
  input  wire logic [15:0] FRM_WLEN,       // Length on the line
  input  wire logic [1:0]  FRM_IFACE,      // Receiving interface
  input  wire logic        FRM_CLASSIFIED, // Emit classified record
  input  wire logic [15:0] FRM_COLOUR,     // Classification colour
  input  wire logic        FRM_DROP,       // Pulse: record lost upstream
  input  wire logic        FRM_VALID,      // Payload byte offered
  input  wire logic [7:0]  FRM_DATA,       // Payload byte
  output logic             FRM_READY,      // Payload byte taken
  output logic             HOST_VALID,     // Word to host memory
  output logic [31:0]      HOST_DATA,      // Lane 0 = lowest address
  output logic [3:0]       HOST_KEEP,      // Valid byte lanes
  output logic             HOST_LAST,      // Last word of record
  input  wire logic        HOST_READY      // Host bus takes word
);
  // ----------------------------------------------------------------------------
  // Timestamp resolution mask
  // ----------------------------------------------------------------------------
  // Coarser stamp engines leave dead low bits; the mask zeroes them
  localparam logic [63:0] TS_MASK =
    ~((64'h1 << (`CRF_TS_FRAC_FULL - TS_FRAC_BITS)) - 64'h1);

  crf_pkg::crf_state_t s;
  crf_pkg::crf_state_t next_s;
  crf_pkg::crf_word_t  fifo_out;
  logic                fifo_ready;
  logic                fifo_valid;
  logic                drop;
  logic [7:0]          type_code;
  logic [7:0]          flags;
  logic [15:0]         fourth;
  logic [2:0]          fill;
  logic [31:0]         acc_new;

  // ----------------------------------------------------------------------------
  // Record builder
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.fresh  = 1'b0;
    fill          = s.cnt + 3'h1;
    acc_new       = s.acc;
    // A start while busy refuses that frame, so it is a lost record
    // overload losses
    drop          = FRM_DROP || (FRM_START && s.st != crf_pkg::CRF_IDLE);
    type_code     = s.classed ? `CRF_TYPE_CLASSIFIED : `CRF_TYPE_PLAIN;
    flags         = {`CRF_FLAGS_CAPOFF, s.iface};
    fourth        = s.classed ? s.colour : s.loss;
    if (s.out_valid && fifo_ready) begin
      next_s.out_valid = 1'b0;
    end
    unique case (s.st)
      crf_pkg::CRF_IDLE: begin
        if (FRM_START) begin
          next_s.ts        = TS_NOW & TS_MASK;
          next_s.rlen      = 16'(`CRF_HDR_BYTES + `CRF_ETH_EXTRA + FRM_LEN);
          next_s.wlen      = FRM_WLEN;
          next_s.iface     = FRM_IFACE;
          next_s.classed   = FRM_CLASSIFIED;
          next_s.colour    = FRM_COLOUR;
          next_s.remaining = FRM_LEN;
          next_s.hw        = 2'h0;
          next_s.st        = crf_pkg::CRF_HDR;
        end
      end
      crf_pkg::CRF_HDR: begin
        // Each word waits for a free slot, so a stalled host loses nothing
        if (!next_s.out_valid) begin
          next_s.out_valid = 1'b1;
          next_s.fresh     = 1'b1;
          next_s.out.keep  = 4'hf;
          next_s.out.last  = 1'b0;
          next_s.hw        = s.hw + 2'h1;
          unique case (s.hw)
            2'h0: next_s.out.data = s.ts[31:0];
            2'h1: next_s.out.data = s.ts[63:32];
            // big-endian fields, first byte in lane 0
            2'h2: next_s.out.data = {s.rlen[7:0], s.rlen[15:8], flags, type_code};
            2'h3: begin
              next_s.out.data = {s.wlen[7:0], s.wlen[15:8], fourth[7:0], fourth[15:8]};
              if (!s.classed) begin
                next_s.loss = `CRF_LOSS_RESET;
              end
              // offset and pad occupy lanes 0 and 1
              next_s.acc = {16'h0000, `CRF_PAD_BYTE, `CRF_OFFSET_BYTE};
              next_s.cnt = 3'h2;
              next_s.st  = crf_pkg::CRF_BODY;
            end
          endcase
        end
      end
      crf_pkg::CRF_BODY: begin
        if (FRM_VALID && s.frm_ready) begin
          acc_new[{s.cnt[1:0], 3'b000} +: 8] = FRM_DATA;
          next_s.acc       = acc_new;
          next_s.cnt       = fill;
          next_s.remaining = s.remaining - 16'h1;
          // The last byte closes the record, mid-word or on a full word; KEEP marks the tail
          if (fill == 3'h4 || s.remaining == 16'h1) begin
            next_s.out.data  = acc_new;
            next_s.out.keep  = 4'(~(4'hf << fill));
            next_s.out.last  = (s.remaining == 16'h1);
            next_s.out_valid = 1'b1;
            next_s.fresh     = 1'b1;
            next_s.acc       = 32'h0;
            next_s.cnt       = 3'h0;
            if (s.remaining == 16'h1) begin
              next_s.st = crf_pkg::CRF_IDLE;
            end
          end
        end
      end
    endcase
    // saturating count; a loss in the clearing cycle survives
    if (drop && next_s.loss != `CRF_LOSS_MAX) begin
      next_s.loss = next_s.loss + 16'h1;
    end
    next_s.frm_ready = (next_s.st == crf_pkg::CRF_BODY) && !next_s.out_valid;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s      <= '0;
      s.st   <= crf_pkg::CRF_IDLE;
      s.loss <= `CRF_LOSS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Host word buffer
  // ----------------------------------------------------------------------------
  // Host stalls back up into FRM_READY through the slot register
  // Eight FIFO words, output stage and slot give ten words of slack
  crf_fifo #(
    .WIDTH ($bits(crf_pkg::crf_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (s.out_valid),
    .in_data   (s.out),
    .in_ready  (fifo_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_out),
    .out_ready (HOST_READY)
  );

  assign FRM_READY  = s.frm_ready;
  assign HOST_VALID = fifo_valid;
  assign HOST_DATA  = fifo_out.data;
  assign HOST_KEEP  = fifo_out.keep;
  assign HOST_LAST  = fifo_out.last;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence ts_lo_loaded;
    s.fresh && s.st == crf_pkg::CRF_HDR && s.hw == 2'h1;
  endsequence
  sequence ts_hi_loaded;
    s.fresh && s.st == crf_pkg::CRF_HDR && s.hw == 2'h2;
  endsequence
  sequence hdr_done;
    s.fresh && s.st == crf_pkg::CRF_BODY && s.cnt == 3'h2;
  endsequence
  sequence frame_begin;
    s.st == crf_pkg::CRF_IDLE && FRM_START;
  endsequence
  sequence start_refused;
    FRM_START && s.st != crf_pkg::CRF_IDLE;
  endsequence
  sequence last_loaded;
    s.fresh && s.out.last;
  endsequence
  sequence host_stalled;
    HOST_VALID && !HOST_READY;
  endsequence

  ts_low_word_a: assert property (
    ts_lo_loaded |-> s.out.data == s.ts[31:0]) else $error("stamp low word wrong");
  ts_high_word_a: assert property (
    ts_hi_loaded |-> s.out.data == s.ts[63:32]) else $error("stamp high word wrong");
  ts_capture_a: assert property (
    (s.st == crf_pkg::CRF_IDLE && FRM_START) |=> s.ts == ($past(TS_NOW) & TS_MASK))
    else $error("stamp not taken at frame start");
  ts_mask_a: assert property (
    (s.ts & ~TS_MASK) == 64'h0) else $error("inactive fraction bits set");
  type_rlen_a: assert property (
    (s.fresh && s.st == crf_pkg::CRF_HDR && s.hw == 2'h3) |->
      s.out.data[7:0] == (s.classed ? 8'h10 : 8'h02) &&
      {s.out.data[23:16], s.out.data[31:24]} == s.rlen)
    else $error("type or record length wrong");
  rlen_total_a: assert property (
    (s.st == crf_pkg::CRF_HDR && $past(s.st) == crf_pkg::CRF_IDLE) |->
      s.rlen == 16'(s.remaining + 16'h12)) else $error("record length not header plus payload");
  wire_len_a: assert property (
    hdr_done |-> {s.out.data[23:16], s.out.data[31:24]} == s.wlen)
    else $error("wire length wrong");
  colour_field_a: assert property (
    (hdr_done and s.classed) |-> {s.out.data[7:0], s.out.data[15:8]} == s.colour)
    else $error("colour missing from classified record");
  loss_clear_a: assert property (
    (hdr_done and !s.classed and !$past(drop)) |-> s.loss == 16'h0)
    else $error("loss count not cleared after delivery");
  loss_step_a: assert property (
    (drop && s.loss != 16'hffff && !(s.st == crf_pkg::CRF_HDR && s.hw == 2'h3 &&
      !s.classed && !(s.out_valid && !fifo_ready))) |=> s.loss == $past(s.loss) + 16'h1)
    else $error("loss count did not step");
  loss_stick_a: assert property (
    (s.loss == 16'hffff && !(s.st == crf_pkg::CRF_HDR)) |=> s.loss == 16'hffff)
    else $error("loss count wrapped");
  byte_order_a: assert property (
    (FRM_VALID && s.frm_ready && s.cnt == 3'h2 && s.remaining > 16'h1) |=>
      s.acc[23:16] == $past(FRM_DATA)) else $error("payload byte misplaced");
  colour_keep_a: assert property (
    (hdr_done and s.classed and !$past(drop)) |-> s.loss == $past(s.loss))
    else $error("classified record cleared loss count");

  // ----------------------------------------------------------------------------
  // Stream checks
  // ----------------------------------------------------------------------------
  start_load_a: assert property (
    frame_begin |=>
      s.st == crf_pkg::CRF_HDR && s.remaining == $past(FRM_LEN))
    else $error("descriptor not loaded at frame start");
  busy_start_a: assert property (
    start_refused |=> s.loss != 16'h0000 && s.rlen == $past(s.rlen))
    else $error("start while busy not refused");
  hdr_word_a: assert property (
    (s.fresh && s.st == crf_pkg::CRF_HDR) |-> s.out.keep == 4'hf && !s.out.last)
    else $error("header word marked partial or last");
  flags_field_a: assert property (
    (s.fresh && s.st == crf_pkg::CRF_HDR && s.hw == 2'h3) |->
      s.out.data[15:8] == {6'h00, s.iface}) else $error("flags byte wrong");
  loss_field_a: assert property (
    (hdr_done and !s.classed) |-> {s.out.data[7:0], s.out.data[15:8]} == $past(s.loss))
    else $error("loss count not delivered");
  pad_bytes_a: assert property (
    hdr_done |-> s.acc[15:0] == 16'h0000 && s.out.keep == 4'hf && !s.out.last)
    else $error("offset or pad byte wrong");
  ready_gap_a: assert property (
    (s.fresh || s.st != crf_pkg::CRF_BODY) |-> !FRM_READY)
    else $error("payload taken outside body or on full slot");
  byte_count_a: assert property (
    (FRM_VALID && FRM_READY) |=> s.remaining == $past(s.remaining) - 16'h1)
    else $error("payload byte count wrong");
  last_word_a: assert property (
    last_loaded |-> s.st == crf_pkg::CRF_IDLE && s.remaining == 16'h0000 &&
      (s.out.keep == 4'h1 || s.out.keep == 4'h3 ||
       s.out.keep == 4'h7 || s.out.keep == 4'hf))
    else $error("record end wrong");
  slot_hold_a: assert property (
    (s.out_valid && !fifo_ready) |=> s.out_valid && $stable(s.out))
    else $error("slot word lost under stall");
  host_hold_a: assert property (
    host_stalled |=> HOST_VALID && $stable(HOST_DATA) && $stable(HOST_KEEP) &&
      $stable(HOST_LAST)) else $error("host word changed while stalled");
endmodule

`default_nettype wire

// File: hw/crf_pkg.sv
// Types shared by the capture record formatter
package crf_pkg;

  typedef enum logic [2:0] {
    CRF_IDLE = 3'b001,
    CRF_HDR  = 3'b010,
    CRF_BODY = 3'b100
  } crf_phase_t;

  // One host-bound word; lane 0 is the lowest byte address
  typedef struct packed {
    logic        last;
    logic [3:0]  keep;
    logic [31:0] data;
  } crf_word_t;

  typedef struct packed {
    crf_phase_t  st;
    logic [1:0]  hw;
    logic [63:0] ts;
    logic [15:0] rlen;
    logic [15:0] wlen;
    logic [15:0] loss;
    logic [15:0] colour;
    logic [1:0]  iface;
    logic        classed;
    logic [31:0] acc;
    logic [2:0]  cnt;
    logic [15:0] remaining;
    crf_word_t   out;
    logic        out_valid;
    logic        fresh;
    logic        frm_ready;
  } crf_state_t;

endpackage

// File: sim/crf_host_model.sv
// Host memory sink model for the capture record formatter
`timescale 1ns/1ps
`default_nettype none

module crf_host_model (
  input  wire logic        clk,   // Capture clock
  input  wire logic        rst,   // Async reset, high
  input  wire logic        valid, // Word offered
  input  wire logic [31:0] data,  // Word data
  input  wire logic [3:0]  keep,  // Valid lanes
  input  wire logic        last,  // Record end
  input  wire logic        stall, // Hold off all words
  input  wire logic        slow,  // Take every other cycle
  output logic             ready  // Word taken
);
  logic [36:0] got[$];
  logic        ph;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ph <= 1'b0;
    else ph <= ~ph;
  end

  assign ready = !stall && (!slow || ph);

  // Stored in arrival order, as memory would see it
  always @(posedge clk) begin
    if (!rst && valid && ready) got.push_back({last, keep, data});
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the capture record formatter
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end

module testbench;
  logic        clock, rst, start, cls, drop, fv, fready;
  logic        hv, hlast, stall, slow, hready;
  logic [63:0] ts;
  logic [15:0] flen, fwlen, col;
  logic [1:0]  ifc;
  logic [7:0]  fd;
  logic [31:0] hdata;
  logic [3:0]  hkeep;
  int          n_errors, comparisons;

  crf_formatter #(.TS_FRAC_BITS(24), .FIFO_DEPTH(8)) uut (
    .CLOCK(clock), .RST(rst), .TS_NOW(ts), .FRM_START(start), .FRM_LEN(flen),
    .FRM_WLEN(fwlen), .FRM_IFACE(ifc), .FRM_CLASSIFIED(cls), .FRM_COLOUR(col),
    .FRM_DROP(drop), .FRM_VALID(fv), .FRM_DATA(fd), .FRM_READY(fready),
    .HOST_VALID(hv), .HOST_DATA(hdata), .HOST_KEEP(hkeep), .HOST_LAST(hlast),
    .HOST_READY(hready));

  crf_host_model host (
    .clk(clock), .rst(rst), .valid(hv), .data(hdata), .keep(hkeep), .last(hlast),
    .stall(stall), .slow(slow), .ready(hready));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic timed_out;
    n_errors++;
    $display("ERROR %0t: wait ran out", $time);
    wrap_up();
  endtask

  // ----------------------------------------------------------------
  // One record: send frame, then judge every host word
  // ----------------------------------------------------------------
  task automatic run_frame(input int len, input logic [1:0] i_f, input logic c,
                           input logic [15:0] fld);
    logic [7:0]  b[$];
    logic [36:0] e[$];
    logic [36:0] g;
    logic [15:0] rl;
    logic        ok;
    int          n, k;
    rl = 16'(18 + len);
    host.got.delete();
    @(posedge clock);
    start <= 1'b1;
    flen <= 16'(len);
    fwlen <= 16'(len + 4);
    ifc <= i_f;
    cls <= c;
    @(posedge clock);
    start <= 1'b0;
    for (int i = 0; i < len; i++) begin
      fv <= 1'b1;
      fd <= 8'(i * 7 + len);
      n = 0;
      do begin
        @(negedge clock) ok = fready;
        @(posedge clock) n++;
      end while (!ok && n < 400);
      if (!ok) timed_out();
    end
    fv <= 1'b0;
    n = 0;
    while ((host.got.size() == 0 || !host.got[$][36]) && n < 400) begin
      @(posedge clock) n++;
    end
    if (n >= 400) timed_out();
    // Low fraction bits masked, seconds in the second word
    e.push_back({5'h0f, 32'h89ab_cd00});
    e.push_back({5'h0f, 32'h6000_0001});
    e.push_back({5'h0f, rl[7:0], rl[15:8], 6'h00, i_f, (c ? 8'h10 : 8'h02)});
    e.push_back({5'h0f, fwlen[7:0], fwlen[15:8], fld[7:0], fld[15:8]});
    b = '{8'h00, 8'h00};
    for (int i = 0; i < len; i++) b.push_back(8'(i * 7 + len));
    k = (b.size() + 3) / 4;
    for (int j = 0; j < k; j++) begin
      g = '0;
      for (int l = 0; l < 4; l++) begin
        if (4 * j + l < b.size()) begin
          g[8 * l +: 8] = b[4 * j + l];
          g[32 + l] = 1'b1;
        end
      end
      g[36] = (j == k - 1);
      e.push_back(g);
    end
    `CHK(host.got.size(), e.size())
    for (int j = 0; j < e.size() && j < host.got.size(); j++) begin
      g = host.got[j];
      if (j == 2) g[15:10] = 6'h00;
      `CHK(g, e[j])
    end
  endtask

  task automatic pulse_drops(input int n);
    @(posedge clock);
    drop <= 1'b1;
    repeat (n) @(posedge clock);
    drop <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_lengths;
    for (int l = 1; l <= 6; l++) run_frame(l, 2'(l), 1'b0, 16'h0000);
  endtask

  task automatic t_loss;
    pulse_drops(3);
    run_frame(5, 2'h1, 1'b0, 16'h0003);
    run_frame(3, 2'h2, 1'b0, 16'h0000);
    pulse_drops(2);
    col <= 16'hbe07;
    run_frame(4, 2'h3, 1'b1, 16'hbe07);
    run_frame(4, 2'h0, 1'b0, 16'h0002);
  endtask

  task automatic t_stall;
    stall <= 1'b1;
    fork
      run_frame(40, 2'h1, 1'b0, 16'h0000);
      begin
        repeat (80) @(posedge clock);
        @(negedge clock);
        `CHK(fready, 1'b0)
        @(posedge clock);
        // Start while busy is refused and counted as one loss
        start <= 1'b1;
        stall <= 1'b0;
        slow <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
      end
    join
    slow <= 1'b0;
    run_frame(1, 2'h2, 1'b0, 16'h0001);
  endtask

  task automatic t_reset;
    pulse_drops(2);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Losses from before a reset do not survive it
    run_frame(3, 2'h1, 1'b0, 16'h0000);
  endtask

  task automatic t_saturate;
    // Held high, one loss per cycle, five cycles past the top
    pulse_drops(65540);
    run_frame(2, 2'h0, 1'b0, 16'hffff);
    run_frame(2, 2'h0, 1'b0, 16'h0000);
  endtask

  initial begin
    n_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    ts = 64'h6000_0001_89ab_cdef;
    {start, cls, drop, fv, stall, slow} = '0;
    {flen, fwlen, col, ifc, fd} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    `CHK({hv, fready}, 2'b00)
    t_lengths();
    t_loss();
    t_reset();
    t_stall();
    t_saturate();
    wrap_up();
  end
endmodule
`default_nettype wire
